// File: core/ctm_regs.svh
// Purpose: Register offsets, field positions, reset values and counts.
// Assumes: Byte-wide registers on a plain strobe port.
// Notes: Offsets are indices of byte registers.
`ifndef CTM_REGS_SVH
`define CTM_REGS_SVH
`define CTM_OFF_CTRL0 3'h0
`define CTM_OFF_CTRL1 3'h1
`define CTM_OFF_CNT_LO 3'h2
`define CTM_OFF_CNT_HI 3'h3
`define CTM_OFF_CMPA_LO 3'h4
`define CTM_OFF_CMPA_HI 3'h5
`define CTM_OFF_FLAGS 3'h6
`define CTM_CTRL0_RST 8'h00
`define CTM_CTRL1_RST 8'h00
`define CTM_CMPA_RST 10'h000
`define CTM_CNT_RST 10'h000
`define CTM_CNT_MAX 10'h3ff
`define CTM_FLAG_A_BIT 0
`define CTM_FLAG_P_BIT 1
`define CTM_PERIOD_STEP 11'h080
`define CTM_PERIOD_FULL 11'h400
`endif

// File: core/ctm_pkg.sv
// Purpose: Types shared by the compact timer files.
// Assumes: Nothing beyond the register header.
// Notes: Control layouts mirror the byte registers bit for bit.
package ctm_pkg;
  typedef enum logic [1:0]
  {
    CTM_MODE_CMP = 2'h0,
    CTM_MODE_UNDEF = 2'h1,
    CTM_MODE_PWM = 2'h2,
    CTM_MODE_TMR = 2'h3
  } ctm_mode_t;
  typedef struct packed
  {
    logic pause;
    logic [2:0] clk_sel;
    logic module_enable;
    logic [2:0] period_compare_value;
  } ctm_ctrl0_t;
  typedef struct packed
  {
    ctm_mode_t mode;
    logic [1:0] output_function;
    logic output_initial_level;
    logic output_invert;
    logic period_duty_swap;
    logic clear_select;
  } ctm_ctrl1_t;
  typedef struct packed
  {
    logic match_a;
    logic match_p;
  } ctm_match_t;
endpackage

// File: core/ctm_tick_sync.sv
// Purpose: Turns the external timer clock pin into one-cycle count ticks.
// Assumes: Pin is asynchronous to clk.
// Notes: Three synchroniser flops and a level flop; an edge counts once the second and third agree.
`timescale 1ns/100ps
module ctm_tick_sync
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  input wire logic falling,
  output logic tick
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  // Synchroniser chain; only s2 reads s1.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Accepted level moves only when the last two stages agree.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      lvl_r <= 1'b0;
    else if (s2_r == s3_r)
      lvl_r <= s3_r;
  end
  // Edge of the chosen direction becomes a tick.
  always_comb
  begin
    if (falling)
      tick = lvl_r & ~s3_r & (s2_r == s3_r);
    else
      tick = ~lvl_r & s3_r & (s2_r == s3_r);
  end
endmodule // ctm_tick_sync

// File: core/ctm_timer.sv
// Purpose: Compact 10-bit count-up timer with compare A and period P.
// Assumes: Byte register port; read data valid the cycle after a read.
// Notes: Clock selects 110/111 use the pin, 100 the ext_tick input, 000-011
//   internal dividers of clk; code 101 stops the counter.
// What this block does
// RULE1: Swap bit picks period and duty comparators.
// RULE2: Clear-select 1 clears counter on A match.
// RULE3: Clear-select 0 clears on P; P=0 wraps.
// RULE4: Counter readable as low and high bytes.
// RULE5: Compare A held in low and high bytes.
// RULE6: Mode field: 00 compare, 10 PWM, 11 timer.
// RULE7: Compare mode sets both match flags.
// RULE8: Clear-select 1 never sets period flag outside PWM.
// RULE9: A zero with clear-select 1: wrap, no flag.
// RULE10: Only A match changes pin in compare mode.
// RULE11: Enable rising edge loads initial pin level.
// RULE12: Timer mode like compare, pin unused.
// RULE13: PWM ignores clear-select; one comparator sets period.
// RULE14: PWM sets both flags on matches.
// RULE15: PWM level, forcing and inversion from control.
// RULE16: Swap 0: period 128 times code, duty A.
// RULE17: Duty at or above period gives full active.
// RULE18: Swap 1: period A, duty 128 times code.
// RULE19: PWM counting continues while output forced.
// RULE20: Enable rise clears counter; fall keeps it.
// RULE21: Compare output codes: keep, low, high, toggle.
// RULE22: PWM output codes: inactive, active, waveform.
// RULE23: Period code compares counter bits 9 to 7.
// RULE24: Count per tick when enabled; flags sticky.
// RULE25: Software stops timer before mode changes.
`timescale 1ns/100ps
`include "ctm_regs.svh"
module ctm_timer
  import ctm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic ext_clk_pin,
  input wire logic ext_tick,
  output logic timer_output_pin_a,
  output logic timer_output_pin_b,
  output logic pin_oe,
  output logic [1:0] match_event
);
  ctm_ctrl0_t ctrl0_r;
  ctm_ctrl1_t ctrl1_r;
  logic [9:0] compare_a_value_r;
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  logic [10:0] cnt_inc;
  logic compare_a_match_flag_r;
  logic period_match_flag_r;
  logic en_d_r;
  logic out_lvl_r;
  logic [5:0] div_r;
  logic pin_tick;
  logic tick;
  logic en_rise;
  logic cnt_en;
  logic a_hit;
  logic p_hit;
  logic clr;
  logic set_a;
  logic set_p;
  logic [10:0] period_len;
  logic [10:0] duty_len;
  logic pwm_active;
  logic pwm_lvl;
  logic out_nxt;
  logic oe_nxt;
  logic [7:0] rdata_nxt;
  logic [1:0] ev_r;
  ctm_match_t hit;

  // Pin clock synchroniser and edge selection.
  ctm_tick_sync u_sync
  (
    .clk(clk),
    .nrst(nrst),
    .pin(ext_clk_pin),
    .falling(ctrl0_r.clk_sel[0]),
    .tick(pin_tick)
  );

  // Free-running divider for internal clock choices.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      div_r <= 6'h00;
    else
      div_r <= div_r + 6'h01;
  end

  // Tick source selection; code 101 gives no ticks.
  always_comb
  begin
    unique case (ctrl0_r.clk_sel)
      3'h0: tick = (div_r[1:0] == 2'h3);
      3'h1: tick = 1'b1;
      3'h2: tick = (div_r[3:0] == 4'hf);
      3'h3: tick = (div_r == 6'h3f);
      3'h4: tick = ext_tick;
      3'h5: tick = 1'b0;
      default: tick = pin_tick;
    endcase
  end

  assign en_rise = ctrl0_r.module_enable & ~en_d_r;
  assign cnt_en = ctrl0_r.module_enable & ~ctrl0_r.pause & tick; // [RULE24]

  // Comparators; P needs the top three bits of the next count equal to the code and its low seven bits zero, so
  // it hits on the last count of a 128-clock multiple (code 0 at 3FF).
  always_comb
  begin
    cnt_inc = {1'b0, cnt_r} + 11'h001;
    hit.match_p = (cnt_inc[9:7] == ctrl0_r.period_compare_value) &
                  (cnt_inc[6:0] == 7'h00); // [RULE23]
    hit.match_a = (cnt_r == compare_a_value_r) &
                  (cnt_r != 10'h000);
  end
  assign a_hit = hit.match_a;
  assign p_hit = hit.match_p;

  // Period and duty lengths for PWM from the swap bit.
  always_comb
  begin
    if (!ctrl1_r.period_duty_swap) // [RULE1]
    begin
      period_len = (ctrl0_r.period_compare_value == 3'h0) ?
                   `CTM_PERIOD_FULL :
                   `CTM_PERIOD_STEP * {8'h00, ctrl0_r.period_compare_value};
      duty_len = {1'b0, compare_a_value_r}; // [RULE16]
    end
    else
    begin
      period_len = (compare_a_value_r == 10'h000) ? `CTM_PERIOD_FULL :
                   {1'b0, compare_a_value_r};
      duty_len = (ctrl0_r.period_compare_value == 3'h0) ?
                 `CTM_PERIOD_FULL :
                 `CTM_PERIOD_STEP * {8'h00, ctrl0_r.period_compare_value};
      // [RULE18]
    end
  end

  // Clear decision: PWM follows the period comparator, else clear_select.
  always_comb
  begin
    clr = 1'b0;
    if (ctrl1_r.mode == CTM_MODE_PWM) // [RULE13]
      clr = ({1'b0, cnt_r} == period_len - 11'h001);
    else if (ctrl1_r.clear_select)
      clr = a_hit | (cnt_r == `CTM_CNT_MAX); // [RULE2] [RULE9]
    else
      clr = p_hit; // [RULE3]
    cnt_nxt = clr ? `CTM_CNT_RST : cnt_r + 10'h001;
  end

  // Flag events per mode.
  always_comb
  begin
    // With the swap bit set in PWM, the A match is the period end itself.
    set_a = cnt_en & (((ctrl1_r.mode == CTM_MODE_PWM) & // [RULE7] [RULE14]
            ctrl1_r.period_duty_swap) ? clr : a_hit); // [RULE9]
    set_p = cnt_en & p_hit & ((ctrl1_r.mode == CTM_MODE_PWM) |
            ~ctrl1_r.clear_select); // [RULE8] [RULE12]
  end

  // Counter: cleared on enable rise, held when off or paused.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= `CTM_CNT_RST;
    else if (en_rise)
      cnt_r <= `CTM_CNT_RST; // [RULE20]
    else if (cnt_en)
      cnt_r <= cnt_nxt; // [RULE24] [RULE19]
  end

  // Enable edge tracker.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      en_d_r <= 1'b0;
    else
      en_d_r <= ctrl0_r.module_enable;
  end

  // Control registers and compare A value written by software.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl0_r <= `CTM_CTRL0_RST;
      ctrl1_r <= `CTM_CTRL1_RST;
      compare_a_value_r <= `CTM_CMPA_RST;
    end
    else if (wr)
    begin
      unique case (addr)
        `CTM_OFF_CTRL0: ctrl0_r <= wdata;
        `CTM_OFF_CTRL1: ctrl1_r <= wdata; // [RULE6] [RULE25]
        `CTM_OFF_CMPA_LO: compare_a_value_r[7:0] <= wdata; // [RULE5]
        `CTM_OFF_CMPA_HI: compare_a_value_r[9:8] <= wdata[1:0]; // [RULE5]
        default: ;
      endcase
    end
  end

  // Sticky flags; writing 1 clears, a new match in the same cycle wins.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      compare_a_match_flag_r <= 1'b0;
      period_match_flag_r <= 1'b0;
    end
    else
    begin
      if (set_a)
        compare_a_match_flag_r <= 1'b1; // [RULE24]
      else if (wr && addr == `CTM_OFF_FLAGS && wdata[`CTM_FLAG_A_BIT])
        compare_a_match_flag_r <= 1'b0;
      if (set_p)
        period_match_flag_r <= 1'b1; // [RULE24]
      else if (wr && addr == `CTM_OFF_FLAGS && wdata[`CTM_FLAG_P_BIT])
        period_match_flag_r <= 1'b0;
    end
  end

  // PWM waveform: active while count is below duty.
  assign pwm_active = (duty_len >= period_len) |
                      ({1'b0, cnt_r} < duty_len); // [RULE17]
  assign pwm_lvl = pwm_active ? ctrl1_r.output_initial_level :
                   ~ctrl1_r.output_initial_level; // [RULE15]

  // Output level per mode.
  always_comb
  begin
    out_nxt = out_lvl_r;
    oe_nxt = 1'b0;
    unique case (ctrl1_r.mode)
      CTM_MODE_CMP:
      begin
        oe_nxt = 1'b1;
        if (en_rise)
          out_nxt = ctrl1_r.output_initial_level; // [RULE11]
        else if (set_a) // [RULE10]
          unique case (ctrl1_r.output_function) // [RULE21]
            2'h0: out_nxt = out_lvl_r;
            2'h1: out_nxt = 1'b0;
            2'h2: out_nxt = 1'b1;
            default: out_nxt = ~out_lvl_r;
          endcase
      end
      CTM_MODE_PWM:
      begin
        oe_nxt = 1'b1;
        unique case (ctrl1_r.output_function) // [RULE22] [RULE19]
          2'h0: out_nxt = ~ctrl1_r.output_initial_level;
          2'h1: out_nxt = ctrl1_r.output_initial_level;
          2'h2: out_nxt = pwm_lvl;
          default: out_nxt = out_lvl_r;
        endcase
      end
      default:
        oe_nxt = 1'b0; // [RULE12]
    endcase
  end

  // Pin state held in a flop; inversion applied at the pins.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_lvl_r <= 1'b0;
      timer_output_pin_a <= 1'b0;
      timer_output_pin_b <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      out_lvl_r <= out_nxt;
      timer_output_pin_a <= out_nxt ^ ctrl1_r.output_invert; // [RULE15]
      timer_output_pin_b <= out_nxt ^ ctrl1_r.output_invert;
      pin_oe <= oe_nxt;
    end
  end

  // Match event pulses for an outside interrupt controller.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ev_r <= 2'h0;
    else
      ev_r <= {set_p, set_a};
  end
  assign match_event = ev_r;

  // Read multiplexer; unused high bits read as zero.
  always_comb
  begin
    unique case (addr)
      `CTM_OFF_CTRL0: rdata_nxt = ctrl0_r;
      `CTM_OFF_CTRL1: rdata_nxt = ctrl1_r;
      `CTM_OFF_CNT_LO: rdata_nxt = cnt_r[7:0]; // [RULE4]
      `CTM_OFF_CNT_HI: rdata_nxt = {6'h00, cnt_r[9:8]}; // [RULE4]
      `CTM_OFF_CMPA_LO: rdata_nxt = compare_a_value_r[7:0];
      `CTM_OFF_CMPA_HI: rdata_nxt = {6'h00, compare_a_value_r[9:8]};
      `CTM_OFF_FLAGS: rdata_nxt = {6'h00, period_match_flag_r,
                                   compare_a_match_flag_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands the cycle after the read strobe, else zero.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd)
      rdata <= rdata_nxt;
    else
      rdata <= 8'h00;
  end
endmodule // ctm_timer

// File: testbench/ctm_timer_assertions.sv
// Purpose: Port checks for the compact timer.
// Assumes: Control bytes are shadowed from bus writes.
// Notes: Bound to every ctm_timer instance.
`timescale 1ns/100ps
module ctm_timer_checker
  import ctm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic ext_clk_pin,
  input wire logic ext_tick,
  input wire logic timer_output_pin_a,
  input wire logic timer_output_pin_b,
  input wire logic pin_oe,
  input wire logic [1:0] match_event
);
  logic en_r;
  logic [7:0] a_lo_r;
  ctm_ctrl1_t c1_r;
  logic cmp_quiet;
  logic pwm_held;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Shadows the enable bit, compare A low byte and second control byte.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      en_r <= 1'b0;
      a_lo_r <= 8'h00;
      c1_r <= '0;
    end
    else if (wr)
    begin
      if (addr == 3'h0)
        en_r <= wdata[3];
      if (addr == 3'h4)
        a_lo_r <= wdata;
      if (addr == 3'h1)
        c1_r <= ctm_ctrl1_t'(wdata);
    end
  end
  // Running setups with no register write in flight.
  assign cmp_quiet = en_r && c1_r.mode == CTM_MODE_CMP && !wr;
  assign pwm_held = en_r && c1_r.mode == CTM_MODE_PWM && !wr
    && !c1_r.output_function[1];
  sequence s_cmp_steady;
    cmp_quiet [*4];
  endsequence
  sequence s_tmr_mode;
    (c1_r.mode == CTM_MODE_TMR) [*3];
  endsequence
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read slot");
  chk_cnt_hi_pad: assert property ($past(rd) && $past(addr) == 3'h3
    |-> rdata[7:2] == 6'h00) else $error("counter high pad not zero");
  chk_cmpa_hi_pad: assert property ($past(rd) && $past(addr) == 3'h5
    |-> rdata[7:2] == 6'h00) else $error("compare high pad not zero");
  chk_cmpa_back: assert property (rd && addr == 3'h4
    |=> rdata == a_lo_r) else $error("compare low byte read back wrong");
  chk_amatch_pin: assert property (s_cmp_steady ##0
    $changed(timer_output_pin_a) |-> match_event[0] || $past(match_event[0])
    || $past(match_event[0], 2)) else $error("pin moved without A match");
  chk_init_level: assert property ($rose(en_r)
    && c1_r.mode == CTM_MODE_CMP |-> ##[1:2] timer_output_pin_a ==
    (c1_r.output_initial_level ^ c1_r.output_invert))
    else $error("pin not at initial level after enable");
  chk_tmr_undriven: assert property (s_tmr_mode |-> !pin_oe)
    else $error("pin driven in timer mode");
  chk_pflag_quiet: assert property ((c1_r.clear_select
    && c1_r.mode != CTM_MODE_PWM) [*3] |-> !match_event[1])
    else $error("period match with clear on A");
  chk_pwm_forced: assert property (pwm_held [*3] |->
    timer_output_pin_a == (~(c1_r.output_initial_level ^
    c1_r.output_function[0]) ^ c1_r.output_invert))
    else $error("forced PWM level wrong");
endmodule // ctm_timer_checker
bind ctm_timer ctm_timer_checker u_ctm_timer_checker
(
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .ext_clk_pin(ext_clk_pin), .ext_tick(ext_tick),
  .timer_output_pin_a(timer_output_pin_a),
  .timer_output_pin_b(timer_output_pin_b), .pin_oe(pin_oe),
  .match_event(match_event)
);

// File: testbench/ctm_pin_partner.sv
// Purpose: External clock source on the timer's input pin.
// Assumes: Pin idles low between bursts.
// Notes: Edges are slow against clk so the synchroniser sees each.
`timescale 1ns/100ps
module ctm_pin_partner
(
  input wire logic clk,
  output logic ext_clk_pin
);
  initial ext_clk_pin = 1'b0;
  // Sends n rising edges, each level held three clocks.
  task automatic send_edges(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge clk);
      ext_clk_pin <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clk_pin <= 1'b0;
    end
  endtask
endmodule // ctm_pin_partner

// File: testbench/tb.sv
// Purpose: Self-checking bench for the compact timer.
// Assumes: Clock select 001 counts every clk.
// Notes: The timer is switched off before each mode change.
`timescale 1ns/100ps
module tb;
  logic clk, nrst, wr, rd, ext_clk_pin, pin_a, pin_b, pin_oe, p;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [1:0] ev;
  int fails, samples_checked, n, i;
  ctm_timer u_ctm_timer (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_clk_pin(ext_clk_pin), .ext_tick(1'b0), .timer_output_pin_a(pin_a),
    .timer_output_pin_b(pin_b), .pin_oe(pin_oe), .match_event(ev));
  ctm_pin_partner u_ctm_pin_partner (.clk(clk), .ext_clk_pin(ext_clk_pin));
  // Compares one value and counts it.
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // Waits for event bit b, then counts clocks to its next pulse.
  task automatic gap(input int b);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
        if (n == 2)
          p = pin_a;
      end
      while (ev[b] !== 1'b1 && n < 3000);
    end
  endtask
  task automatic t_regs;
    for (i = 0; i < 8; i++)
    begin
      rd_reg(i[2:0]);
      chk(d, 8'h00);
    end
    wr_reg(3'h4, 8'h5a);
    wr_reg(3'h5, 8'hff);
    wr_reg(3'h2, 8'hff);
    rd_reg(3'h4);
    chk(d, 8'h5a);
    rd_reg(3'h5);
    chk(d, 8'h03);
    rd_reg(3'h2);
    chk(d, 8'h00);
  endtask
  task automatic t_cmp;
    logic [7:0] c1 [5] = '{8'h21, 8'h01, 8'h19, 8'h31, 8'h3d};
    logic e0 [5] = '{0, 0, 1, 0, 0};
    logic e1 [5] = '{1, 0, 0, 1, 1};
    wr_reg(3'h4, 8'h05);
    wr_reg(3'h5, 8'h00);
    for (i = 0; i < 5; i++)
    begin
      wr_reg(3'h0, 8'h10);
      wr_reg(3'h1, c1[i]);
      wr_reg(3'h0, 8'h18);
      repeat (3) @(negedge clk);
      chk(pin_a, e0[i]);
      chk(pin_b, e0[i]);
      gap(0);
      chk(n, 6);
      chk(p, e1[i]);
    end
  endtask
  task automatic t_period;
    wr_reg(3'h0, 8'h10);
    wr_reg(3'h1, 8'hc0);
    wr_reg(3'h0, 8'h19);
    gap(1);
    chk(n, 128);
    gap(0);
    chk(n, 128);
    chk(pin_oe, 1'b0);
    rd_reg(3'h6);
    chk(d[1:0], 2'b11);
    wr_reg(3'h0, 8'h10);
    wr_reg(3'h6, 8'h03);
    rd_reg(3'h6);
    chk(d[1:0], 2'b00);
    wr_reg(3'h0, 8'h18);
    gap(0);
    chk(n, 1024);
  endtask
  task automatic t_pwm;
    logic [7:0] c1 [6] = '{8'ha9, 8'ha9, 8'hab, 8'h89, 8'h99, 8'had};
    int a [6] = '{32, 200, 100, 32, 32, 32};
    int w [6] = '{128, 128, 100, 128, 128, 128};
    int e [6] = '{32, 128, 100, 0, 128, 96};
    for (i = 0; i < 6; i++)
    begin
      wr_reg(3'h0, 8'h11);
      wr_reg(3'h4, a[i][7:0]);
      wr_reg(3'h1, c1[i]);
      wr_reg(3'h0, 8'h19);
      gap(c1[i][1] ? 0 : 1);
      if (!c1[i][1])
        chk(n, 128);
      chk(pin_oe, 1'b1);
      n = 0;
      repeat (w[i])
      begin
        @(negedge clk);
        if (pin_a === 1'b1)
          n++;
      end
      chk(n, e[i]);
    end
  endtask
  task automatic t_ext;
    wr_reg(3'h0, 8'h10);
    wr_reg(3'h1, 8'hc0);
    wr_reg(3'h0, 8'h68);
    u_ctm_pin_partner.send_edges(5);
    repeat (8) @(posedge clk);
    rd_reg(3'h2);
    chk(d, 8'h05);
    wr_reg(3'h0, 8'h60);
    rd_reg(3'h2);
    chk(d, 8'h05);
    wr_reg(3'h0, 8'h68);
    rd_reg(3'h2);
    chk(d, 8'h00);
    wr_reg(3'h0, 8'h78);
    u_ctm_pin_partner.send_edges(2);
    repeat (8) @(posedge clk);
    wr_reg(3'h0, 8'hf8);
    u_ctm_pin_partner.send_edges(1);
    repeat (8) @(posedge clk);
    rd_reg(3'h2);
    chk(d, 8'h02);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Free-running 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Cuts a hang short well beyond the expected run.
  initial
  begin
    #400000;
    fails++;
    stop_test;
  end
  // Reset, then each scenario in turn.
  initial
  begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    fails = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_cmp;
    t_period;
    t_pwm;
    t_ext;
    stop_test;
  end
endmodule // tb
